// ==== hdl/lpm_clk_mon.sv ====
`timescale 1ns/1ns
// Watches a toggling sample of the external clock; missing toggles flag failure
module lpm_clk_mon #(
  parameter int WIN = 64
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Monitor
  input  wire logic i_enable,
  input  wire logic i_ext_toggle,
  output logic      o_fail
);

  logic [$clog2(WIN+1)-1:0] cnt_q;
  logic [$clog2(WIN+1)-1:0] cnt_d;
  logic                     meta_q;
  logic                     s1_q;
  logic                     s2_q;
  logic                     fail_q;
  logic                     fail_d;

  always_comb begin
    cnt_d  = cnt_q;
    fail_d = 1'b0;
    if (!i_enable || (s1_q != s2_q)) begin
      cnt_d = '0;
    end else if (cnt_q == WIN[$clog2(WIN+1)-1:0]) begin
      fail_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      meta_q <= 1'b0;
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      meta_q <= i_ext_toggle;
      s1_q   <= meta_q;
      s2_q   <= s1_q;
      fail_q <= fail_d;
    end
  end

  assign o_fail = fail_q;

endmodule : lpm_clk_mon

// ==== hdl/lpm_ctrl.sv ====
`timescale 1ns/1ns
module lpm_ctrl #(
  parameter int SYS_MHZ_MAX = 48,
  parameter int PRE_W       = 4
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // Supply comparators
  input  wire logic                   i_main_supply_ok,
  input  wire logic                   i_analog_supply_ok,
  input  wire logic                   i_analog_watch_off,
  input  wire logic                   i_supply_above_thr,
  // Supply voltage detector control
  input  wire logic                   i_svd_enable,
  input  wire logic                   i_svd_irq_fall_en,
  input  wire logic                   i_svd_irq_rise_en,
  // Low-power request
  input  wire logic                   i_wait_req,
  input  wire lpm_pkg::lpm_sel_e      i_mode_sel,
  input  wire logic                   i_stop_low_power,
  // Wake sources
  input  wire logic [23:0]            i_wake_lines,
  input  wire logic [23:0]            i_wake_mask,
  input  wire logic                   i_periph_irq,
  input  wire logic                   i_rc_request,
  input  wire logic                   i_reset_pin,
  input  wire logic                   i_watchdog_reset,
  input  wire logic                   i_wake_up_pin,
  input  wire logic                   i_calendar_event,
  input  wire logic                   i_regulator_ready,
  // Clock control
  input  wire lpm_pkg::lpm_clk_e      i_clk_sel,
  input  wire logic                   i_ext_toggle,
  input  wire logic                   i_clk_fail_irq_en,
  input  wire logic [7:0]             i_sys_mhz,
  input  wire logic [PRE_W-1:0]       i_hbus_pre,
  input  wire logic [PRE_W-1:0]       i_pbus_pre,
  // Outputs
  output logic                        o_chip_resetn,
  output lpm_pkg::lpm_reg_s           o_regulator,
  output lpm_pkg::lpm_gate_s          o_gates,
  output lpm_pkg::lpm_state_e         o_state,
  output lpm_pkg::lpm_clk_e           o_clk_active,
  output logic                        o_rc_clk_grant,
  output logic                        o_svd_irq,
  output logic                        o_clk_fail_irq,
  output logic [PRE_W-1:0]            o_hbus_pre,
  output logic [PRE_W-1:0]            o_pbus_pre
);

  // ****************************************
  // Synchronisers and external clock monitor
  // ****************************************
  logic [3:0] sync_lvl;
  logic [3:0] sync_rise;
  logic       ext_fail;

  lpm_sync_edge #(.W(4)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({i_wake_up_pin, i_calendar_event, i_watchdog_reset, i_reset_pin}),
    .o_level  (sync_lvl),
    .o_rise   (sync_rise)
  );

  lpm_clk_mon #(.WIN(lpm_pkg::LPM_MON_CYC)) u_mon (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_enable     (o_clk_active != lpm_pkg::LPM_CLK_RC),
    .i_ext_toggle (i_ext_toggle),
    .o_fail       (ext_fail)
  );

  // ****************************************
  // Supply supervisors
  // ****************************************
  logic supply_bad;
  logic chip_resetn_q;
  logic chip_resetn_d;

  always_comb begin
    // Analog watch unless i_analog_watch_off is set; main supply watched in every state
    supply_bad    = !i_main_supply_ok || (!i_analog_watch_off && !i_analog_supply_ok);
    chip_resetn_d = !supply_bad;
  end

  // ****************************************
  // Supply voltage detector
  // ****************************************
  logic above_q;
  logic above_d;
  logic svd_irq_q;
  logic svd_irq_d;

  always_comb begin
    above_d   = i_supply_above_thr;
    svd_irq_d = 1'b0;
    if (i_svd_enable) begin
      svd_irq_d = (i_svd_irq_fall_en && above_q && !i_supply_above_thr)
               || (i_svd_irq_rise_en && !above_q && i_supply_above_thr);
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  lpm_pkg::lpm_state_e state_q;
  lpm_pkg::lpm_state_e state_d;
  lpm_pkg::lpm_reg_s   reg_q;
  lpm_pkg::lpm_reg_s   reg_d;
  lpm_pkg::lpm_gate_s  gate_q;
  lpm_pkg::lpm_gate_s  gate_d;
  logic                grant_q;
  logic                grant_d;
  logic                stop_wake;
  logic                stby_wake;

  always_comb begin
    stop_wake = |(i_wake_lines & i_wake_mask);
    stby_wake = |sync_rise;
    state_d   = state_q;
    grant_d   = 1'b0;
    case (state_q)
      lpm_pkg::LPM_RUN: begin
        if (i_wait_req) begin
          case (i_mode_sel)
            lpm_pkg::LPM_SEL_SLEEP: state_d = lpm_pkg::LPM_SLEEP;
            lpm_pkg::LPM_SEL_STOP:  state_d = lpm_pkg::LPM_STOP;
            lpm_pkg::LPM_SEL_STBY:  state_d = lpm_pkg::LPM_STANDBY;
            default:                state_d = lpm_pkg::LPM_RUN;
          endcase
        end
      end
      lpm_pkg::LPM_SLEEP: begin
        if (i_periph_irq || stop_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (stop_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end else if (i_rc_request) begin
          if (reg_q.low_power) begin
            state_d = lpm_pkg::LPM_REGWAKE;
          end else begin
            grant_d = 1'b1;
          end
        end
      end
      lpm_pkg::LPM_REGWAKE: begin
        // Clock withheld until the main regulator reports ready
        if (i_regulator_ready) begin
          state_d = lpm_pkg::LPM_STOP;
          grant_d = i_rc_request;
        end
      end
      lpm_pkg::LPM_STANDBY: begin
        if (stby_wake) begin
          state_d = lpm_pkg::LPM_RUN;
        end
      end
      default: state_d = lpm_pkg::LPM_RUN;
    endcase

    // Regulator and gating follow the next state
    reg_d.main_on         = 1'b1;
    reg_d.low_power       = 1'b0;
    reg_d.off             = 1'b0;
    gate_d.cpu_clk_en     = 1'b1;
    gate_d.core_clk_en    = 1'b1;
    gate_d.osc_en         = 1'b1;
    gate_d.rtc_wdg_run    = 1'b1;
    case (state_d)
      lpm_pkg::LPM_SLEEP: begin
        gate_d.cpu_clk_en = 1'b0;
      end
      lpm_pkg::LPM_STOP: begin
        gate_d.cpu_clk_en  = 1'b0;
        gate_d.core_clk_en = 1'b0;
        gate_d.osc_en      = grant_d;
        // Low-power regulator released while the RC is granted
        reg_d.low_power    = i_stop_low_power && !grant_d && state_q != lpm_pkg::LPM_REGWAKE;
        reg_d.main_on      = !reg_d.low_power;
      end
      lpm_pkg::LPM_REGWAKE: begin
        gate_d.cpu_clk_en  = 1'b0;
        gate_d.core_clk_en = 1'b0;
        gate_d.osc_en      = 1'b0;
      end
      lpm_pkg::LPM_STANDBY: begin
        gate_d.cpu_clk_en  = 1'b0;
        gate_d.core_clk_en = 1'b0;
        gate_d.osc_en      = 1'b0;
        reg_d.main_on      = 1'b0;
        reg_d.off          = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // Clock source and bus prescalers
  // ****************************************
  lpm_pkg::lpm_clk_e clk_q;
  lpm_pkg::lpm_clk_e clk_d;
  logic              cfail_irq_q;
  logic              cfail_irq_d;
  logic              fail_lock_q;
  logic              fail_lock_d;
  logic [PRE_W-1:0]  hpre_q;
  logic [PRE_W-1:0]  hpre_d;
  logic [PRE_W-1:0]  ppre_q;
  logic [PRE_W-1:0]  ppre_d;

  function automatic logic [PRE_W-1:0] fit_pre(input logic [7:0] mhz,
                                                input logic [PRE_W-1:0] pre);
    logic [PRE_W-1:0] p;
    p = pre;
    // Raise the divide exponent until the bus stays within its ceiling
    for (int k = 0; k < (1 << PRE_W); k++) begin
      if ((32'(mhz) >> p) > 32'(SYS_MHZ_MAX) && p != '1) begin
        p = p + 1'b1;
      end
    end
    return p;
  endfunction : fit_pre

  always_comb begin
    clk_d       = clk_q;
    fail_lock_d = fail_lock_q;
    cfail_irq_d = 1'b0;
    if (ext_fail && clk_q != lpm_pkg::LPM_CLK_RC) begin
      clk_d       = lpm_pkg::LPM_CLK_RC;
      fail_lock_d = 1'b1;
      cfail_irq_d = i_clk_fail_irq_en;
    end else if (state_q == lpm_pkg::LPM_RUN && !fail_lock_q) begin
      clk_d = i_clk_sel;
    end else if (i_clk_sel == lpm_pkg::LPM_CLK_RC) begin
      // Software acknowledges a failure by going back to RC
      fail_lock_d = 1'b0;
    end
    if (state_d == lpm_pkg::LPM_STOP || state_d == lpm_pkg::LPM_STANDBY) begin
      clk_d = lpm_pkg::LPM_CLK_RC;
    end
    hpre_d = fit_pre(i_sys_mhz, i_hbus_pre);
    ppre_d = fit_pre(i_sys_mhz >> hpre_d, i_pbus_pre);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      chip_resetn_q <= 1'b0;
      above_q       <= 1'b1;
      svd_irq_q     <= 1'b0;
      state_q       <= lpm_pkg::LPM_RUN;
      reg_q         <= '{main_on: 1'b1, low_power: 1'b0, off: 1'b0};
      gate_q        <= '1;
      grant_q       <= 1'b0;
      clk_q         <= lpm_pkg::LPM_CLK_RC;
      fail_lock_q   <= 1'b0;
      cfail_irq_q   <= 1'b0;
      hpre_q        <= lpm_pkg::LPM_PRE_RST;
      ppre_q        <= lpm_pkg::LPM_PRE_RST;
    end else begin
      chip_resetn_q <= chip_resetn_d;
      above_q       <= above_d;
      svd_irq_q     <= svd_irq_d;
      state_q       <= state_d;
      reg_q         <= reg_d;
      gate_q        <= gate_d;
      grant_q       <= grant_d;
      clk_q         <= clk_d;
      fail_lock_q   <= fail_lock_d;
      cfail_irq_q   <= cfail_irq_d;
      hpre_q        <= hpre_d;
      ppre_q        <= ppre_d;
    end
  end

  assign o_chip_resetn  = chip_resetn_q;
  assign o_regulator    = reg_q;
  assign o_gates        = gate_q;
  assign o_state        = state_q;
  assign o_clk_active   = clk_q;
  assign o_rc_clk_grant = grant_q;
  assign o_svd_irq      = svd_irq_q;
  assign o_clk_fail_irq = cfail_irq_q;
  assign o_hbus_pre     = hpre_q;
  assign o_pbus_pre     = ppre_q;

  // ****************************************
  // Checks
  // ****************************************
  supply_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_main_supply_ok |=> !o_chip_resetn) else $error("Reset not held on low supply");

  analog_watch_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_main_supply_ok && i_analog_watch_off) |=> o_chip_resetn)
    else $error("Analog watch not disabled");

  svd_fall_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_svd_enable && i_svd_irq_fall_en && $fell(i_supply_above_thr)) |=> o_svd_irq)
    else $error("Missed detector fall interrupt");

  regulator_on_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_state != lpm_pkg::LPM_STANDBY) |-> !o_regulator.off)
    else $error("Regulator off outside standby");

  sleep_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_state == lpm_pkg::LPM_SLEEP) |-> (!o_gates.cpu_clk_en && o_gates.core_clk_en))
    else $error("Sleep gating wrong");

  stop_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_state == lpm_pkg::LPM_STOP) |-> !o_gates.core_clk_en)
    else $error("Core clocks running in stop");

  stop_wake_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_q == lpm_pkg::LPM_STOP && |(i_wake_lines & i_wake_mask))
    |=> (o_state == lpm_pkg::LPM_RUN)) else $error("Stop did not wake");

  rc_after_main_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_rc_clk_grant |-> !o_regulator.low_power)
    else $error("Clock granted on low-power regulator");

  standby_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_state == lpm_pkg::LPM_STANDBY) |-> (o_regulator.off && !o_gates.osc_en))
    else $error("Standby not powered off");

  rtc_runs_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_gates.rtc_wdg_run) else $error("Calendar clock stopped");

  clk_fallback_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (ext_fail && o_clk_active != lpm_pkg::LPM_CLK_RC) |=> (o_clk_active == lpm_pkg::LPM_CLK_RC))
    else $error("No fallback to internal RC");

endmodule : lpm_ctrl

// ==== hdl/lpm_pkg.sv ====
package lpm_pkg;

  // ****************************************
  // Modes and clock sources
  // ****************************************
  typedef enum logic [2:0] {
    LPM_RUN     = 3'b000,
    LPM_SLEEP   = 3'b001,
    LPM_STOP    = 3'b010,
    LPM_REGWAKE = 3'b011,
    LPM_STANDBY = 3'b100
  } lpm_state_e;

  typedef enum logic [1:0] {
    LPM_SEL_RUN   = 2'b00,
    LPM_SEL_SLEEP = 2'b01,
    LPM_SEL_STOP  = 2'b10,
    LPM_SEL_STBY  = 2'b11
  } lpm_sel_e;

  typedef enum logic [1:0] {
    LPM_CLK_RC  = 2'b00,
    LPM_CLK_EXT = 2'b01,
    LPM_CLK_PLL = 2'b10
  } lpm_clk_e;

  // ****************************************
  // Grouped signals
  // ****************************************
  typedef struct packed {
    logic main_on;
    logic low_power;
    logic off;
  } lpm_reg_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic osc_en;
    logic rtc_wdg_run;
  } lpm_gate_s;

  // ****************************************
  // Constants
  // ****************************************
  localparam int          LPM_CLK_MHZ      = 50;
  localparam int          LPM_REGWAKE_NS   = 100;
  localparam int          LPM_REGWAKE_CYC  = (LPM_REGWAKE_NS * LPM_CLK_MHZ + 999) / 1000;
  localparam int          LPM_BUS_MAX_MHZ  = 48;
  localparam int          LPM_EXT_MIN_MHZ  = 4;
  localparam int          LPM_EXT_MAX_MHZ  = 32;
  localparam int          LPM_RC_MHZ       = 8;
  localparam int          LPM_PIN_LINES    = 16;
  localparam int          LPM_WAKE_LINES   = 24;
  localparam int          LPM_MON_CYC      = 64;
  localparam logic [1:0]  LPM_SRC_RST      = 2'h0;
  localparam logic [3:0]  LPM_PRE_RST      = 4'h0;
  localparam logic [15:0] LPM_PRE_POS      = 16'h0;

endpackage : lpm_pkg

// ==== hdl/lpm_sync_edge.sv ====
`timescale 1ns/1ns
// Two-stage synchroniser with rising edge detect on the second stage output
module lpm_sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~last_q;

endmodule : lpm_sync_edge

// ==== verif/lpm_ctrl_tb.sv ====
`timescale 1ns/1ns
module lpm_ctrl_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0, resetn = 1'b0, main_ok = 1'b1, ana_ok = 1'b1, ana_off = 1'b0;
  logic above = 1'b1, wait_req = 1'b0, stop_lp = 1'b0, periph = 1'b0, rc_req = 1'b0;
  logic ext_run = 1'b0, fail_en = 1'b0, chip_resetn, grant, svd_irq, fail_irq, rdy, tog;
  logic [2:0]          svd_cfg = 3'h0;
  logic [3:0]          stby_src = 4'h0;
  logic [3:0]          hpre = 4'h0, ppre = 4'h0, ready_dly = 4'h3, hout, pout;
  logic [7:0]          sys_mhz = 8'h30;
  logic [23:0]         wake = 24'h0, mask = 24'h0;
  lpm_pkg::lpm_sel_e   mode_sel = lpm_pkg::LPM_SEL_RUN;
  lpm_pkg::lpm_clk_e   clk_sel = lpm_pkg::LPM_CLK_RC;
  lpm_pkg::lpm_clk_e   clk_act;
  lpm_pkg::lpm_reg_s   regulator;
  lpm_pkg::lpm_gate_s  gates;
  lpm_pkg::lpm_state_e state;
  int                  errors = 0, samples_checked = 0, cycles = 0, svd_n = 0, fail_n = 0;
  localparam logic [2:0] CFGS [4] = '{3'h6, 3'h5, 3'h7, 3'h3};
  localparam logic [7:0] SYS [4] = '{8'h30, 8'h31, 8'h60, 8'hc8};
  localparam logic [7:0] HEXP [4] = '{8'h0, 8'h1, 8'h1, 8'h3};

  always #10 clk = ~clk;

  lpm_ctrl i_lpm_ctrl (
    .i_clk(clk), .i_resetn(resetn), .i_main_supply_ok(main_ok),
    .i_analog_supply_ok(ana_ok), .i_analog_watch_off(ana_off), .i_supply_above_thr(above),
    .i_svd_enable(svd_cfg[2]), .i_svd_irq_fall_en(svd_cfg[1]), .i_svd_irq_rise_en(svd_cfg[0]),
    .i_wait_req(wait_req), .i_mode_sel(mode_sel), .i_stop_low_power(stop_lp),
    .i_wake_lines(wake), .i_wake_mask(mask), .i_periph_irq(periph), .i_rc_request(rc_req),
    .i_reset_pin(stby_src[0]), .i_watchdog_reset(stby_src[1]), .i_wake_up_pin(stby_src[2]),
    .i_calendar_event(stby_src[3]), .i_regulator_ready(rdy), .i_clk_sel(clk_sel),
    .i_ext_toggle(tog), .i_clk_fail_irq_en(fail_en), .i_sys_mhz(sys_mhz),
    .i_hbus_pre(hpre), .i_pbus_pre(ppre), .o_chip_resetn(chip_resetn),
    .o_regulator(regulator), .o_gates(gates), .o_state(state), .o_clk_active(clk_act),
    .o_rc_clk_grant(grant), .o_svd_irq(svd_irq), .o_clk_fail_irq(fail_irq),
    .o_hbus_pre(hout), .o_pbus_pre(pout));

  lpm_far_model i_lpm_far_model (
    .i_clk(clk), .i_resetn(resetn), .i_regulator(regulator), .i_osc_en(gates.osc_en),
    .i_ready_dly(ready_dly), .i_ext_run(ext_run), .o_regulator_ready(rdy),
    .o_ext_toggle(tog));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic check_state(input lpm_pkg::lpm_state_e exp);
    samples_checked++;
    if (state !== exp) begin
      errors++;
      $display("FAIL state expected %s seen %h", exp.name(), state);
    end
  endtask : check_state

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic done(input string t);
    $display("test %s finished, mismatches %0d", t, errors);
  endtask : done

  // Core side asks for a mode with a one-cycle wait indication
  task automatic enter(input lpm_pkg::lpm_sel_e sel, input logic lp);
    tick(1);
    mode_sel = sel;
    stop_lp = lp;
    wait_req = 1'b1;
    tick(1);
    wait_req = 1'b0;
  endtask : enter

  task automatic wait_state(input lpm_pkg::lpm_state_e exp, input int max);
    for (int i = 0; i < max && state !== exp; i++) tick(1);
    check_state(exp);
  endtask : wait_state

  task automatic svd_step(input logic lvl, input logic [7:0] exp);
    int n0;
    n0 = svd_n;
    above = lvl;
    tick(4);
    check("svd pulses", exp, 8'(svd_n - n0));
  endtask : svd_step

  // Pulses are counted off the sampling edge, where outputs have settled
  always @(negedge clk) begin
    cycles++;
    if (svd_irq === 1'b1) svd_n++;
    if (fail_irq === 1'b1) fail_n++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int n0;
    tick(5);
    check("chip_resetn in reset", 8'h0, {7'h0, chip_resetn});
    check_state(lpm_pkg::LPM_RUN);
    check("reset regulator", 8'h4, {5'h0, regulator});
    check("reset gates", 8'hf, {4'h0, gates});
    check("reset clock", 8'h0, {6'h0, clk_act});
    resetn = 1'b1;
    tick(2);
    check("chip_resetn ok", 8'h1, {7'h0, chip_resetn});
    main_ok = 1'b0;
    tick(1);
    check("chip_resetn main low", 8'h0, {7'h0, chip_resetn});
    main_ok = 1'b1;
    ana_ok = 1'b0;
    tick(1);
    check("chip_resetn analog low", 8'h0, {7'h0, chip_resetn});
    ana_off = 1'b1;
    tick(1);
    check("chip_resetn analog off", 8'h1, {7'h0, chip_resetn});
    ana_ok = 1'b1;
    done("supply");
    for (int i = 0; i < 4; i++) begin
      svd_cfg = CFGS[i];
      svd_step(1'b0, {7'h0, CFGS[i][2] & CFGS[i][1]});
      svd_step(1'b1, {7'h0, CFGS[i][2] & CFGS[i][0]});
    end
    done("detector");
    enter(lpm_pkg::LPM_SEL_SLEEP, 1'b0);
    check_state(lpm_pkg::LPM_SLEEP);
    check("sleep gates", 8'h7, {4'h0, gates});
    clk_sel = lpm_pkg::LPM_CLK_EXT;
    tick(2);
    check("sleep clock", 8'h0, {6'h0, clk_act});
    clk_sel = lpm_pkg::LPM_CLK_RC;
    periph = 1'b1;
    wait_state(lpm_pkg::LPM_RUN, 4);
    periph = 1'b0;
    done("sleep");
    for (int i = 0; i < 24; i++) begin
      mask = 24'h1 << i;
      enter(lpm_pkg::LPM_SEL_STOP, i[0]);
      wake = ~mask;
      tick(2);
      check_state(lpm_pkg::LPM_STOP);
      check("stop regulator", i[0] ? 8'h2 : 8'h4, {5'h0, regulator});
      check("stop gates", 8'h1, {4'h0, gates});
      wake = mask;
      wait_state(lpm_pkg::LPM_RUN, 4);
      wake = 24'h0;
    end
    done("stop");
    ready_dly = 4'h6;
    enter(lpm_pkg::LPM_SEL_STOP, 1'b1);
    tick(2);
    rc_req = 1'b1;
    tick(1);
    check_state(lpm_pkg::LPM_REGWAKE);
    check("regwake grant", 8'h0, {7'h0, grant});
    check("regwake main", 8'h1, {7'h0, regulator.main_on});
    wait_state(lpm_pkg::LPM_STOP, 20);
    check("stop grant", 8'h1, {7'h0, grant});
    check("stop osc", 8'h1, {7'h0, gates.osc_en});
    rc_req = 1'b0;
    wake = mask;
    wait_state(lpm_pkg::LPM_RUN, 4);
    wake = 24'h0;
    ready_dly = 4'h1;
    done("regwake");
    enter(lpm_pkg::LPM_SEL_STOP, 1'b1);
    resetn = 1'b0;
    tick(2);
    check_state(lpm_pkg::LPM_RUN);
    check("rerun regulator", 8'h4, {5'h0, regulator});
    check("rerun chip_resetn", 8'h0, {7'h0, chip_resetn});
    resetn = 1'b1;
    tick(2);
    check("rerun clock", 8'h0, {6'h0, clk_act});
    check("rerun chip_resetn ok", 8'h1, {7'h0, chip_resetn});
    done("reset");
    for (int i = 0; i < 4; i++) begin
      enter(lpm_pkg::LPM_SEL_STBY, 1'b0);
      check_state(lpm_pkg::LPM_STANDBY);
      check("standby regulator", 8'h1, {5'h0, regulator});
      check("standby gates", 8'h1, {4'h0, gates});
      stby_src = 4'h1 << i;
      wait_state(lpm_pkg::LPM_RUN, 8);
      stby_src = 4'h0;
      tick(4);
    end
    done("standby");
    for (int j = 0; j < 2; j++) begin
      fail_en = !j[0];
      clk_sel = lpm_pkg::LPM_CLK_EXT;
      ext_run = 1'b1;
      tick(6);
      check("clock external", 8'h1, {6'h0, clk_act});
      n0 = fail_n;
      ext_run = 1'b0;
      tick(60);
      check("clock held", 8'h1, {6'h0, clk_act});
      tick(20);
      check("fail pulses", {7'h0, fail_en}, 8'(fail_n - n0));
      check("clock fallback", 8'h0, {6'h0, clk_act});
      clk_sel = lpm_pkg::LPM_CLK_RC;
      tick(2);
    end
    clk_sel = lpm_pkg::LPM_CLK_PLL;
    tick(2);
    check("clock pll", 8'h2, {6'h0, clk_act});
    clk_sel = lpm_pkg::LPM_CLK_RC;
    tick(2);
    done("clock monitor");
    for (int i = 0; i < 4; i++) begin
      sys_mhz = SYS[i];
      tick(2);
      check("hbus prescaler", HEXP[i], {4'h0, hout});
      check("pbus rate", 8'h1, {7'h0, ((sys_mhz >> hout) >> pout) <= 8'h30});
    end
    hpre = 4'h2;
    ppre = 4'h1;
    sys_mhz = 8'h30;
    tick(2);
    check("hbus kept", 8'h2, {4'h0, hout});
    check("pbus kept", 8'h1, {4'h0, pout});
    done("prescaler");
    conclude();
  end
endmodule : lpm_ctrl_tb

// ==== verif/lpm_far_model.sv ====
`timescale 1ns/1ns
// ****************************************
// Far side: main regulator settling and external crystal
// ****************************************
module lpm_far_model (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // From the block
  input  wire lpm_pkg::lpm_reg_s i_regulator,
  input  wire logic              i_osc_en,
  // Bench control
  input  wire logic [3:0]        i_ready_dly,
  input  wire logic              i_ext_run,
  // To the block
  output logic                   o_regulator_ready,
  output logic                   o_ext_toggle
);
  logic [3:0] settle_q;

  // Ready only after main mode has been held for the settle time; slow when delay is large
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_regulator.main_on) begin
      settle_q          <= 4'h0;
      o_regulator_ready <= 1'b0;
    end else begin
      if (settle_q < i_ready_dly) begin
        settle_q <= settle_q + 4'h1;
      end
      o_regulator_ready <= (settle_q >= i_ready_dly);
    end
  end

  // A stopped or dead crystal stands still, which the monitor has to notice
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ext_toggle <= 1'b0;
    end else if (i_osc_en && i_ext_run) begin
      o_ext_toggle <= !o_ext_toggle;
    end
  end
endmodule : lpm_far_model
